/* design/crm_pkg.sv */
// shared constants and types for the cable reflectometry monitor
package crm_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int SAMPLE_W = 8;
  localparam int TIMER_W = 8;
  localparam int WIDTH_W = 3;

  localparam logic [4:0] CONTROL_OFFSET = 5'h16;
  localparam logic [4:0] WINDOW_OFFSET = 5'h17;
  localparam logic [4:0] PEAK_OFFSET = 5'h18;
  localparam logic [4:0] THRESHOLD_OFFSET = 5'h19;

  localparam int CTL_ENABLE_BIT = 15;
  localparam int CTL_FAST_BIT = 14;
  localparam int CTL_TX_ON_RX_BIT = 13;
  localparam int CTL_WATCH_RX_BIT = 12;
  localparam int CTL_LAUNCH_BIT = 11;
  localparam int CTL_WIDTH_HI = 10;
  localparam int CTL_WIDTH_LO = 8;
  localparam int CTL_MIN_MODE_BIT = 7;
  localparam int CTL_WIN_EN_BIT = 6;
  localparam int CTL_THR_HI = 5;
  localparam int CTL_THR_LO = 0;

  localparam int WIN_START_HI = 15;
  localparam int WIN_START_LO = 8;
  localparam int WIN_STOP_HI = 7;
  localparam int WIN_STOP_LO = 0;
  localparam int RES_TIME_HI = 15;
  localparam int RES_TIME_LO = 8;
  localparam int RES_VALUE_HI = 7;
  localparam int RES_VALUE_LO = 0;

  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [7:0] WIN_START_RESET = 8'h00;
  localparam logic [7:0] WIN_STOP_RESET = 8'hff;
  localparam logic [7:0] TIMER_LAST = 8'hff;

  localparam int CLK_PERIOD_NS = 10;
  localparam int FAST_STEP_NS = 8;
  localparam int SLOW_SHORT_NS = 50;
  localparam int SLOW_LONG_NS = 100;
  localparam logic [2:0] SLOW_LONG_MIN_WIDTH = 3'h4;
  // least times, rounded up to whole clocks
  localparam int SLOW_SHORT_CYC = (SLOW_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOW_LONG_CYC = (SLOW_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CNT_W = 5;

  typedef enum logic [1:0] {
    CRM_IDLE = 2'b01,
    CRM_RUN = 2'b10
  } crm_state_e;
endpackage

/* design/crm_pulse_if.sv */
// launch request and line driver signals between monitor and pulse generator
`timescale 1ns/1ns
interface crm_pulse_if;
  logic launch;
  logic fast_mode;
  logic [2:0] width;
  logic busy;
  logic fast_drive_pos;
  logic fast_drive_neg;
  logic slow_drive;

  modport gen (
    input launch,
    input fast_mode,
    input width,
    output busy,
    output fast_drive_pos,
    output fast_drive_neg,
    output slow_drive
  );
  modport ctl (
    input busy,
    input fast_drive_pos,
    input fast_drive_neg,
    input slow_drive,
    output launch,
    output fast_mode,
    output width
  );
endinterface

/* design/crm_pulse_gen.sv */
// test pulse generator for the fast and slow line drivers
`timescale 1ns/1ns
module crm_pulse_gen
  import crm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  crm_pulse_if.gen pif
);
  typedef struct packed {
    logic [PULSE_CNT_W-1:0] count;
    logic fast;
    logic negative;
    logic busy;
    logic drive_pos;
    logic drive_neg;
    logic drive_slow;
  } crm_gen_s;

  crm_gen_s st;
  crm_gen_s next_st;
  logic [PULSE_CNT_W-1:0] len;

  always_comb begin
    // fast steps of 8 ns rounded up to clocks; slow pulses are 50 or 100 ns
    len = PULSE_CNT_W'((int'(pif.width) * FAST_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    if (!pif.fast_mode) begin
      len = (pif.width >= SLOW_LONG_MIN_WIDTH) ? PULSE_CNT_W'(SLOW_LONG_CYC) :
                                                 PULSE_CNT_W'(SLOW_SHORT_CYC);
    end
    next_st = st;
    if (st.busy) begin
      if (st.count <= PULSE_CNT_W'(1)) begin
        next_st.busy = 1'b0;
        next_st.count = '0;
      end else begin
        next_st.count = st.count - PULSE_CNT_W'(1);
      end
    end else if (pif.launch && pif.width != 3'h0) begin
      next_st.busy = 1'b1;
      next_st.count = len;
      next_st.fast = pif.fast_mode;
      // alternate fast pulse polarity on each fast launch taken while not busy and at nonzero width
      if (pif.fast_mode) begin
        next_st.negative = ~st.negative;
      end
    end
    // driver lines leave straight from flops, so no decode glitch reaches the line
    next_st.drive_pos = next_st.busy && next_st.fast && !next_st.negative;
    next_st.drive_neg = next_st.busy && next_st.fast && next_st.negative;
    next_st.drive_slow = next_st.busy && !next_st.fast;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pif.busy = st.busy;
  assign pif.fast_drive_pos = st.drive_pos;
  assign pif.fast_drive_neg = st.drive_neg;
  assign pif.slow_drive = st.drive_slow;
endmodule

/* design/crm_monitor.sv */
// cable reflectometry monitor: registers, timer, window and echo detection
`timescale 1ns/1ns
module crm_monitor
  import crm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] mgmt_addr,
  input wire logic mgmt_wr_en,
  input wire logic [DATA_W-1:0] mgmt_wr_data,
  output logic [DATA_W-1:0] mgmt_rd_data,
  input wire logic [SAMPLE_W-1:0] adc_sample,
  input wire logic adc_valid,
  output logic diag_active,
  output logic pulse_on_rx_pair,
  output logic watch_rx_pair,
  output logic measuring,
  output logic fast_drive_pos,
  output logic fast_drive_neg,
  output logic slow_drive
);
  typedef struct packed {
    crm_state_e state;
    logic enable;
    logic fast;
    logic tx_on_rx;
    logic watch_rx;
    logic [WIDTH_W-1:0] width;
    logic min_mode;
    logic win_en;
    logic [5:0] threshold;
    logic [TIMER_W-1:0] win_start;
    logic [TIMER_W-1:0] win_stop;
    logic [TIMER_W-1:0] timer;
    logic peak_seen;
    logic [SAMPLE_W-1:0] peak_value;
    logic [TIMER_W-1:0] peak_time;
    logic thr_seen;
    logic [SAMPLE_W-1:0] thr_value;
    logic [TIMER_W-1:0] thr_time;
    logic launch;
    logic [DATA_W-1:0] rd_data;
  } crm_mon_s;

  crm_mon_s st;
  crm_mon_s next_st;

  crm_pulse_if pif ();

  crm_pulse_gen u_pulse_gen (
    .ref_clk(ref_clk),
    .reset(reset),
    .pif(pif)
  );

  // launch is a one-clock strobe from a flop, settings come from the stored control
  assign pif.launch = st.launch;
  assign pif.fast_mode = st.fast;
  assign pif.width = st.width;

  logic signed [SAMPLE_W:0] oriented;
  logic signed [SAMPLE_W:0] peak_oriented;
  logic signed [SAMPLE_W:0] thr_level;
  logic in_window;
  logic last_sample;
  logic start_req;
  logic [DATA_W-1:0] ctrl_view;
  logic [DATA_W-1:0] win_view;

  always_comb begin
    // sign-extend one bit so negating the most negative code cannot overflow
    oriented = {adc_sample[SAMPLE_W-1], adc_sample};
    peak_oriented = {st.peak_value[SAMPLE_W-1], st.peak_value};
    if (st.min_mode) begin
      oriented = -oriented;
      peak_oriented = -peak_oriented;
    end
    thr_level = {3'h0, st.threshold};

    in_window = 1'b1;
    if (st.win_en) begin
      in_window = (st.timer >= st.win_start) && (st.timer <= st.win_stop);
    end
    last_sample = st.win_en ? (st.timer == st.win_stop) : (st.timer == TIMER_LAST);

    start_req = mgmt_wr_en && mgmt_addr == CONTROL_OFFSET && mgmt_wr_data[CTL_LAUNCH_BIT];

    ctrl_view = CONTROL_RESET;
    ctrl_view[CTL_ENABLE_BIT] = st.enable;
    ctrl_view[CTL_FAST_BIT] = st.fast;
    ctrl_view[CTL_TX_ON_RX_BIT] = st.tx_on_rx;
    ctrl_view[CTL_WATCH_RX_BIT] = st.watch_rx;
    // launch bit reads back as measurement in progress
    ctrl_view[CTL_LAUNCH_BIT] = (st.state == CRM_RUN);
    ctrl_view[CTL_WIDTH_HI:CTL_WIDTH_LO] = st.width;
    ctrl_view[CTL_MIN_MODE_BIT] = st.min_mode;
    ctrl_view[CTL_WIN_EN_BIT] = st.win_en;
    ctrl_view[CTL_THR_HI:CTL_THR_LO] = st.threshold;
    win_view = {st.win_start, st.win_stop};

    next_st = st;
    next_st.launch = 1'b0;

    // register writes; settings are frozen while a measurement runs
    if (mgmt_wr_en && st.state == CRM_IDLE) begin
      unique case (mgmt_addr)
        CONTROL_OFFSET: begin
          next_st.enable = mgmt_wr_data[CTL_ENABLE_BIT];
          next_st.fast = mgmt_wr_data[CTL_FAST_BIT];
          next_st.tx_on_rx = mgmt_wr_data[CTL_TX_ON_RX_BIT];
          next_st.watch_rx = mgmt_wr_data[CTL_WATCH_RX_BIT];
          next_st.width = mgmt_wr_data[CTL_WIDTH_HI:CTL_WIDTH_LO];
          next_st.min_mode = mgmt_wr_data[CTL_MIN_MODE_BIT];
          next_st.win_en = mgmt_wr_data[CTL_WIN_EN_BIT];
          next_st.threshold = mgmt_wr_data[CTL_THR_HI:CTL_THR_LO];
        end
        WINDOW_OFFSET: begin
          next_st.win_start = mgmt_wr_data[WIN_START_HI:WIN_START_LO];
          next_st.win_stop = mgmt_wr_data[WIN_STOP_HI:WIN_STOP_LO];
        end
        default: begin
        end
      endcase
    end

    unique case (st.state)
      CRM_IDLE: begin
        // launch needs the diagnostic enabled in the same write
        if (start_req && mgmt_wr_data[CTL_ENABLE_BIT]) begin
          next_st.state = CRM_RUN;
          next_st.launch = 1'b1;
          next_st.timer = '0;
          next_st.peak_seen = 1'b0;
          next_st.peak_value = '0;
          next_st.peak_time = '0;
          next_st.thr_seen = 1'b0;
          next_st.thr_value = '0;
          next_st.thr_time = '0;
        end
      end
      CRM_RUN: begin
        // a second launch here is simply not looked at
        if (!st.enable) begin
          next_st.state = CRM_IDLE;
        end else if (adc_valid) begin
          if (in_window) begin
            // strict compare keeps the first occurrence of the extreme
            if (!st.peak_seen || oriented > peak_oriented) begin
              next_st.peak_seen = 1'b1;
              next_st.peak_value = adc_sample;
              next_st.peak_time = st.timer;
            end
            if (!st.thr_seen && oriented > thr_level) begin
              next_st.thr_seen = 1'b1;
              next_st.thr_value = adc_sample;
              next_st.thr_time = st.timer;
            end
          end
          if (last_sample) begin
            next_st.state = CRM_IDLE;
          end else begin
            next_st.timer = st.timer + TIMER_W'(1);
          end
        end
      end
    endcase

    // read data follows the address with one clock of latency
    unique case (mgmt_addr)
      CONTROL_OFFSET: next_st.rd_data = ctrl_view;
      WINDOW_OFFSET: next_st.rd_data = win_view;
      PEAK_OFFSET: next_st.rd_data = {st.peak_time, st.peak_value};
      THRESHOLD_OFFSET: next_st.rd_data = {st.thr_time, st.thr_value};
      default: next_st.rd_data = '0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
      st.state <= CRM_IDLE;
      st.win_start <= WIN_START_RESET;
      st.win_stop <= WIN_STOP_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign mgmt_rd_data = st.rd_data;
  assign diag_active = st.enable;
  assign pulse_on_rx_pair = st.tx_on_rx;
  assign watch_rx_pair = st.watch_rx;
  // one-hot run bit, so the output is the flop itself
  assign measuring = st.state[1];
  // drivers pass straight from the pulse generator, with no gating by the enable
  assign fast_drive_pos = pif.fast_drive_pos;
  assign fast_drive_neg = pif.fast_drive_neg;
  assign slow_drive = pif.slow_drive;
endmodule

/* test/crm_cable_model.sv */
// cable model: converter samples from a table while the monitor runs
`timescale 1ns/1ns
module crm_cable_model
  import crm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic measuring,
  input wire logic [SAMPLE_W-1:0] echo [256],
  output logic [SAMPLE_W-1:0] adc_sample,
  output logic adc_valid
);
  logic [8:0] idx;
  // one sample every other clock; the bus never holds a stale value between samples
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      idx <= 9'h000;
      adc_valid <= 1'b0;
      adc_sample <= 8'h00;
    end else begin
      adc_valid <= measuring && !adc_valid;
      adc_sample <= (measuring && !adc_valid) ? echo[idx[7:0]] : ~adc_sample;
      idx <= measuring ? idx + {8'h00, !adc_valid} : 9'h000;
    end
  end
endmodule

/* test/crm_monitor_asserts.sv */
// port assertions for the reflectometry monitor
`timescale 1ns/1ns
module crm_monitor_asserts
  import crm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] mgmt_addr,
  input wire logic mgmt_wr_en,
  input wire logic [DATA_W-1:0] mgmt_wr_data,
  input wire logic [DATA_W-1:0] mgmt_rd_data,
  input wire logic [SAMPLE_W-1:0] adc_sample,
  input wire logic adc_valid,
  input wire logic diag_active,
  input wire logic pulse_on_rx_pair,
  input wire logic watch_rx_pair,
  input wire logic measuring,
  input wire logic fast_drive_pos,
  input wire logic fast_drive_neg,
  input wire logic slow_drive
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic ctl_wr;
  logic go;
  logic drv;
  assign ctl_wr = mgmt_wr_en && mgmt_addr == CONTROL_OFFSET && !measuring;
  assign go = ctl_wr && mgmt_wr_data[15] && mgmt_wr_data[11];
  assign drv = fast_drive_pos || fast_drive_neg || slow_drive;
  property p_go; go |=> measuring; endproperty
  a_go: assert property (p_go) else $error("launch ignored");
  property p_diag; ctl_wr |=> diag_active == $past(mgmt_wr_data[15]); endproperty
  a_diag: assert property (p_diag) else $error("enable not taken");
  property p_pairs;
    ctl_wr && mgmt_wr_data[15] |=> {pulse_on_rx_pair, watch_rx_pair} == $past(mgmt_wr_data[13:12]);
  endproperty
  a_pairs: assert property (p_pairs) else $error("pair select wrong");
  property p_off; !diag_active |-> !drv; endproperty
  a_off: assert property (p_off) else $error("drive while disabled");
  property p_sign; !(fast_drive_pos && fast_drive_neg); endproperty
  a_sign: assert property (p_sign) else $error("both signs driven");
  property p_slow; $rose(slow_drive) |-> slow_drive [*5]; endproperty
  a_slow: assert property (p_slow) else $error("slow pulse short");
  property p_w0; go && mgmt_wr_data[10:8] == 3'h0 |=> !drv [*8]; endproperty
  a_w0: assert property (p_w0) else $error("pulse at width zero");
  // ending needs a sample; write cycles left out
  property p_hold;
    measuring && !adc_valid && !$past(adc_valid) && !mgmt_wr_en |=> measuring;
  endproperty
  a_hold: assert property (p_hold) else $error("early end");
endmodule
bind crm_monitor crm_monitor_asserts chk_u (.*);

/* test/tb_top.sv */
// self-checking bench for the reflectometry monitor
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
  import crm_pkg::*;
  logic ref_clk, reset, mgmt_wr_en, adc_valid, diag_active, pulse_on_rx_pair, watch_rx_pair;
  logic measuring, fast_drive_pos, fast_drive_neg, slow_drive;
  logic [ADDR_W-1:0] mgmt_addr;
  logic [DATA_W-1:0] mgmt_wr_data, mgmt_rd_data;
  logic [SAMPLE_W-1:0] adc_sample;
  logic [SAMPLE_W-1:0] echo [256];
  int failures = 0, n_compared = 0, cycles = 0;
  // first fast pulse after reset is negative
  bit neg_next = 1'b1;
  crm_monitor dut_u (.*);
  crm_cable_model cable_u (.*);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    mgmt_addr <= a;
    mgmt_wr_data <= d;
    mgmt_wr_en <= 1'b1;
    @(posedge ref_clk);
    mgmt_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    mgmt_addr <= a;
    repeat (2) @(posedge ref_clk);
    #1;
    d = mgmt_rd_data;
  endtask
  function automatic logic [31:0] expect_res(logic [15:0] c, logic [15:0] w);
    int o, best, lo, hi;
    logic [15:0] pk, th;
    best = 0;
    pk = 16'h0000;
    th = 16'h0000;
    lo = c[6] ? w[15:8] : 0;
    hi = c[6] ? w[7:0] : 255;
    for (int t = lo; t <= hi; t++) begin
      o = $signed(echo[t]);
      if (c[7]) o = -o;
      if (o > best) begin
        best = o;
        pk = {8'(t), echo[t]};
      end
      if (o > int'(c[5:0]) && th == 16'h0000) th = {8'(t), echo[t]};
    end
    return {pk, th};
  endfunction
  task automatic run(input logic [15:0] c, input logic [15:0] w, input bit poke);
    int fp, fn, sl, n;
    fp = 0;
    fn = 0;
    sl = 0;
    wr(WINDOW_OFFSET, w);
    wr(CONTROL_OFFSET, c);
    // writes landing mid-run must be dropped
    if (poke) begin
      wr(WINDOW_OFFSET, ~w);
      wr(CONTROL_OFFSET, c ^ 16'h40ff);
    end
    for (int i = 0; i < 700; i++) begin
      @(posedge ref_clk);
      #1;
      fp += fast_drive_pos + fast_drive_neg;
      sl += slow_drive;
      fn += fast_drive_neg;
      if (measuring === 1'b0 && i > 12) break;
    end
    `CHK("ended", 1'b0, measuring)
    n = c[10:8] == 0 ? 0 : c[14] ? (c[10:8] * 8 + 9) / 10 : c[10:8] > 3 ? 10 : 5;
    if (!poke) `CHK("fast", c[14] ? n : 0, fp)
    if (!poke) `CHK("slow", c[14] ? 0 : n, sl)
    if (!poke) `CHK("fast neg", neg_next && c[14] ? n : 0, fn)
    // sign flips on every fast launch that really sends a pulse
    if (c[14] && c[10:8] != 3'h0) neg_next = !neg_next;
  endtask
  initial begin
    logic [15:0] c, w, r;
    logic [31:0] e;
    int st, sp;
    reset = 1'b1;
    mgmt_wr_en = 1'b0;
    mgmt_addr = 5'h00;
    mgmt_wr_data = 16'h0000;
    void'($urandom(32'hd06db881));
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    rd(WINDOW_OFFSET, r);
    `CHK("win rst", 16'h00ff, r)
    rd(CONTROL_OFFSET, r);
    `CHK("ctl rst", CONTROL_RESET, r)
    rd(5'h1a, r);
    `CHK("unmapped", 16'h0000, r)
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      c = 16'($urandom);
      c[15] = 1'b1;
      c[11] = 1'b1;
      if (k == 0) c[10:8] = 3'h0;
      if (k == 3) c[6] = 1'b0;
      // full window from zero only where the pulse leaves on the other pair
      if (k == 2) c[13] = ~c[12];
      st = $urandom_range(0, 190);
      if (c[12] == c[13]) st = st | 16;
      sp = (k == 1) ? st : st + $urandom_range(0, 40);
      w = (k == 2) ? 16'h00ff : {8'(st), 8'(sp)};
      for (int t = 0; t < 256; t++) echo[t] = 8'($urandom_range(0, 254) - 127);
      echo[c[6] ? w[7:0] : 255] = c[7] ? 8'hce : 8'h32;
      e = expect_res(c, w);
      run(c, w, k == 3);
      `CHK("diag", 1'b1, diag_active)
      `CHK("pairs", c[13:12], {pulse_on_rx_pair, watch_rx_pair})
      rd(PEAK_OFFSET, r);
      `CHK("peak", e[31:16], r)
      rd(THRESHOLD_OFFSET, r);
      `CHK("thr", e[15:0], r)
      rd(WINDOW_OFFSET, r);
      `CHK("win", w, r)
      rd(CONTROL_OFFSET, r);
      `CHK("ctl", c & 16'hf7ff, r)
      $display("test %0d done", k);
    end
    wrap_up();
  end
endmodule
